// [rtl/gpio_port.sv]
// configurable parallel input/output port behind an axi4-lite slave
// assumes one clock, synchronous active-low reset, synchronous port inputs
// Overview of operation
// - width parameter 1 to 32, port buses only; axi data stays 32 bits
// - bidirectional bit shares one pin
// - per-bit direction, input bits undriven
// - input only: sampled inputs, no drivers
// - output only: drivers, no sampling
// - in-out mode: separate input, output buses
// - output only: no capture, no interrupt
// - capture enabled: per-bit flags, fixed edge
// - capture disabled: no flag register
// - level irq: input high and enabled
// - edge irq: flag set and enabled
// - irq disabled: no enable register, quiet
// - any write to flags clears all but bits with a new edge that cycle
// - reset clears direction and enables
// - data read inputs, write output register
// - irq holds while cause and enable hold; an edge cause holds until cleared
`default_nettype none
`include "gpio_defs.svh"
module gpio_port
   import gpio_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter dir_mode_t DIR_MODE = DIR_BIDIR,
   parameter bit CAPTURE_EN = 1'b1,
   parameter edge_kind_t EDGE_KIND = EDGE_RISE,
   parameter bit IRQ_EN = 1'b1,
   parameter irq_kind_t IRQ_KIND = IRQ_LEVEL
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [WIDTH-1:0] port_in,
   output logic [WIDTH-1:0] port_out,
   output logic [WIDTH-1:0] port_oe,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   // configuration flags
   // input side exists unless output only
   localparam bit HAS_IN = (DIR_MODE != DIR_OUT_ONLY);
   localparam bit HAS_OUT = (DIR_MODE != DIR_IN_ONLY);
   localparam bit HAS_DIR = (DIR_MODE == DIR_BIDIR);
   // output-only mode forbids input options
   localparam bit HAS_CAP = CAPTURE_EN && HAS_IN;
   localparam bit HAS_IRQ = IRQ_EN && HAS_IN;

   // width range is guarded by width_range_a in the assertion section

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [WIDTH-1:0] out_q; // output drive register
   logic [WIDTH-1:0] dir_q; // direction, 1 = drive
   logic [WIDTH-1:0] mask_q; // interrupt enables
   logic [WIDTH-1:0] edge_flags; // sticky edge flags
   logic [WIDTH-1:0] in_s; // sampled inputs
   logic [3:0] wa_q; // held write address
   logic [31:0] wd_q; // held write data
   logic [3:0] ws_q; // held write strobes
   logic aw_have_q; // address taken
   logic w_have_q; // data taken
   logic wr_go; // both halves present this cycle
   logic edge_clr; // any write to flag register
   wr_state_t ws_st_q; // write response state
   logic [WIDTH-1:0] wmask; // strobes widened to bits

   ////////////////////////////////////////////////////////////////////////////
   // input sampling
   if (HAS_IN) begin : g_in
      // inputs go through one sample stage
      in_sampler #(.W(WIDTH)) u_samp (
         .aclk(aclk),
         .aresetn(aresetn),
         .ce(ce),
         .d(port_in),
         .q(in_s)
      );
   end else begin : g_no_in
      // output only: pins not sampled
      assign in_s = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge capture
   if (HAS_CAP) begin : g_cap
      for (genvar i = 0; i < WIDTH; i++) begin : g_bit
         // one sticky flag per bit, fixed edge kind
         edge_bit #(.KIND(EDGE_KIND)) u_edge (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .sample(in_s[i]),
            .clear(edge_clr),
            .flag(edge_flags[i])
         );
      end
   end else begin : g_no_cap
      // no flag register exists
      assign edge_flags = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi write channel: address and data taken in either order
   assign s_axi_awready = !aw_have_q && ws_st_q == WS_IDLE;
   assign s_axi_wready = !w_have_q && ws_st_q == WS_IDLE;
   assign wr_go = aw_have_q && w_have_q && ws_st_q == WS_IDLE;
   assign edge_clr = wr_go && wa_q == `OFS_EDGE && HAS_CAP;
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         wmask[i] = ws_q[i/8];
      end
   end

   // capture address half
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         wa_q <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            wa_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_q <= 1'b0;
         end
      end
   end

   // capture data half
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // write response; unmapped addresses are okay as ignored writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ws_st_q <= WS_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (ce) begin
         case (ws_st_q)
            WS_IDLE: begin
               if (wr_go) begin
                  ws_st_q <= WS_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= `RESP_OKAY;
               end
            end
            WS_RESP: begin
               if (s_axi_bready) begin
                  ws_st_q <= WS_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               ws_st_q <= WS_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers written by software
   // output drive register; data writes never touch the read path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_q <= `RST_OUT;
      end else if (ce && wr_go && wa_q == `OFS_DATA && HAS_OUT) begin
         out_q <= (out_q & ~wmask) | (wd_q[WIDTH-1:0] & wmask);
      end
   end

   // direction register, bidirectional mode only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dir_q <= `RST_DIR;
      end else if (ce && wr_go && wa_q == `OFS_DIR && HAS_DIR) begin
         dir_q <= (dir_q & ~wmask) | (wd_q[WIDTH-1:0] & wmask);
      end
   end

   // interrupt enable register, present only with irq
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= `RST_IMASK;
      end else if (ce && wr_go && wa_q == `OFS_IMASK && HAS_IRQ) begin
         mask_q <= (mask_q & ~wmask) | (wd_q[WIDTH-1:0] & wmask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive
   // bidirectional: drive only bits marked output; others float
   always_comb begin
      case (DIR_MODE)
         DIR_BIDIR: port_oe = dir_q;
         DIR_IN_ONLY: port_oe = '0;
         default: port_oe = '1;
      endcase
   end
   assign port_out = HAS_OUT ? out_q : '0;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt: registered, level holds while cause and enable hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         if (!HAS_IRQ) begin
            irq <= 1'b0;
         end else if (IRQ_KIND == IRQ_LEVEL) begin
            irq <= |(in_s & mask_q);
         end else begin
            irq <= |(edge_flags & mask_q);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi read channel, one cycle latency
   assign s_axi_arready = !s_axi_rvalid;

   // read mux; absent registers read as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= `FILL_ABSENT;
            case (s_axi_araddr)
               `OFS_DATA: if (HAS_IN) s_axi_rdata[WIDTH-1:0] <= in_s;
               `OFS_DIR: if (HAS_DIR) s_axi_rdata[WIDTH-1:0] <= dir_q;
               `OFS_IMASK: if (HAS_IRQ) s_axi_rdata[WIDTH-1:0] <= mask_q;
               `OFS_EDGE: if (HAS_CAP) s_axi_rdata[WIDTH-1:0] <= edge_flags;
               default: s_axi_rresp <= `RESP_OKAY;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // write data cut to the port width, for the drive check
   logic [WIDTH-1:0] wd_bits;
   assign wd_bits = wd_q[WIDTH-1:0];

   // configuration, reset and pin drive
   width_range_a: assert property (WIDTH >= 1 && WIDTH <= 32)
      else $error("port width outside 1 to 32");
   dir_reset_a: assert property ($rose(aresetn) |-> dir_q == '0 && mask_q == '0)
      else $error("direction or enable not zero after reset");
   oe_follow_a: assert property (DIR_MODE == DIR_BIDIR |-> port_oe == dir_q)
      else $error("drive enable differs from direction");
   in_only_a: assert property (DIR_MODE == DIR_IN_ONLY |-> port_oe == '0)
      else $error("input-only mode drives pins");

   // interrupt behaviour
   level_irq_a: assert property (ce && HAS_IRQ && IRQ_KIND == IRQ_LEVEL && |(in_s & mask_q) |=> irq)
      else $error("level interrupt missing");
   edge_irq_a: assert property (ce && HAS_IRQ && IRQ_KIND == IRQ_EDGE && |(edge_flags & mask_q) |=> irq)
      else $error("edge interrupt missing");
   no_irq_a: assert property (!HAS_IRQ |-> !irq)
      else $error("interrupt raised while disabled");
   irq_drop_a: assert property (ce && HAS_IRQ && mask_q == '0 |=> !irq)
      else $error("interrupt held with all enables clear");

   // edge flags: after a clear only bits that moved may be set again
   edge_clear_a: assert property (ce && $past(ce) && edge_clr
      |=> (edge_flags & ~($past(in_s) ^ $past(in_s, 2))) == '0)
      else $error("edge flag survived a clear without a new edge");
   // flags never drop on their own while no clear arrives
   edge_sticky_a: assert property (ce && HAS_CAP && !edge_clr
      |=> (edge_flags & $past(edge_flags)) == $past(edge_flags))
      else $error("edge flag dropped without a clear");
   // rising capture: every rising bit of the sample sets its flag
   edge_set_a: assert property (ce && $past(ce) && HAS_CAP && EDGE_KIND == EDGE_RISE
      |=> (edge_flags & $past(in_s) & ~$past(in_s, 2)) == ($past(in_s) & ~$past(in_s, 2)))
      else $error("rising edge not captured");

   // bus handshakes and the data register
   rd_answer_a: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   // a paired write is answered on the next edge
   wr_answer_a: assert property (ce && wr_go |=> s_axi_bvalid)
      else $error("write not answered next cycle");
   // answers stand until the master takes them
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer withdrawn before it was taken");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed before it was taken");
   // data reads come from the sampled inputs, never the drive register
   data_read_a: assert property (ce && s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_DATA && HAS_IN
      |=> s_axi_rdata[WIDTH-1:0] == $past(in_s))
      else $error("data read does not return the sampled inputs");
   // a full-word data write lands on the outputs
   out_write_a: assert property (ce && wr_go && wa_q == `OFS_DATA && ws_q == 4'hf && HAS_OUT
      |=> port_out == $past(wd_bits))
      else $error("data write not driven on the outputs");

   // scenario covers
   wr_cov_c: cover property (wr_go && wa_q == `OFS_DATA);
   edge_cov_c: cover property (edge_clr);
   irq_cov_c: cover property ($rose(irq));
   rd_cov_c: cover property (s_axi_rvalid && s_axi_rready);
   edge_set_c: cover property (ce && |edge_flags);
endmodule
`default_nettype wire

// [rtl/gpio_defs.svh]
// register offsets, field values and reset values for the parallel port
// assumes inclusion by bare name from the design files
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH
`define OFS_DATA 4'h0
`define OFS_DIR 4'h4
`define OFS_IMASK 4'h8
`define OFS_EDGE 4'hc
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RST_DIR 32'h0000_0000
`define RST_IMASK 32'h0000_0000
`define RST_EDGE 32'h0000_0000
`define RST_OUT 32'h0000_0000
`define FILL_ABSENT 32'h0000_0000
`endif

// [rtl/gpio_pkg.sv]
// types shared by the parallel port design
// assumes nothing of its surroundings
`default_nettype none
package gpio_pkg;
   // port direction configuration
   typedef enum logic [1:0] {
      DIR_BIDIR = 2'h0,
      DIR_IN_ONLY = 2'h1,
      DIR_OUT_ONLY = 2'h2,
      DIR_IN_OUT = 2'h3
   } dir_mode_t;
   // edge kind to capture
   typedef enum logic [1:0] {
      EDGE_RISE = 2'h0,
      EDGE_FALL = 2'h1,
      EDGE_ANY = 2'h2
   } edge_kind_t;
   // interrupt source
   typedef enum logic {
      IRQ_LEVEL = 1'b0,
      IRQ_EDGE = 1'b1
   } irq_kind_t;
   // write channel pairing state, gray along the path
   typedef enum logic [1:0] {
      WS_IDLE = 2'b00,
      WS_RESP = 2'b01
   } wr_state_t;
endpackage
`default_nettype wire

// [rtl/edge_bit.sv]
// one bit of the sticky edge capture flag
// assumes input already synchronous to aclk
`default_nettype none
module edge_bit
   import gpio_pkg::*;
#(
   parameter edge_kind_t KIND = EDGE_RISE
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic sample,
   input wire logic clear,
   output logic flag
);
   logic prev_q; // value seen one clock earlier
   logic hit; // configured transition seen now

   // compare current sample with previous one
   always_comb begin
      case (KIND)
         EDGE_RISE: hit = sample & ~prev_q;
         EDGE_FALL: hit = ~sample & prev_q;
         default: hit = sample ^ prev_q;
      endcase
   end

   // previous-sample register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_q <= 1'b0;
      end else if (ce) begin
         prev_q <= sample;
      end
   end

   // sticky flag; a new edge beats the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag <= 1'b0;
      end else if (ce) begin
         if (hit) begin
            flag <= 1'b1;
         end else if (clear) begin
            flag <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [rtl/in_sampler.sv]
// input sample register for the port inputs
// assumes inputs synchronous to aclk
`default_nettype none
module in_sampler #(
   parameter int W = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // one register stage so reads and edges see the same value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// [verif/pin_model.sv]
// far-side model of the bidirectional pins and the logic behind them
// assumes one clock shared with the port; ext_oe marks bits driven from outside
`default_nettype none
module pin_model #(
   parameter int W = 32
) (
   input wire logic aclk,
   input wire logic [W-1:0] port_out,
   input wire logic [W-1:0] port_oe,
   input wire logic [W-1:0] ext_val,
   input wire logic [W-1:0] ext_oe,
   output logic [W-1:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [W-1:0] last_q; // last resolved level of each pin
   ////////////////////////////////////////////////////////////////////////
   // resolve each shared pin, port side wins when it drives
   // a pin nobody drives floats: show the inverse of its last level
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (port_oe[i]) begin
            pin[i] = port_out[i];
         end else if (ext_oe[i]) begin
            pin[i] = ext_val[i];
         end else begin
            pin[i] = ~last_q[i];
         end
      end
   end
   // remember the level for the floating case
   always_ff @(posedge aclk) begin
      last_q <= pin;
   end
endmodule
`default_nettype wire

// [verif/configurable_parallel_io_port_test.sv]
// self-checking bench for the parallel port: bidir, rising capture, level irq
// assumes the design files and pin_model are compiled first
`default_nettype none
`include "gpio_defs.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
   $display("ERROR %0t mismatch got %h exp %h", $time, got, exp); end end
module configurable_parallel_io_port_test;
   import gpio_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0; // 200 MHz
   logic aresetn = 1'b0; // active low
   logic ce = 1'b1; // always running
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, port_out, port_oe, pin, rd_val, old_v;
   logic [31:0] ext_val = 32'h0; // outside drive value
   logic [31:0] ext_oe = 32'hffff_ffff; // outside drives all at start
   int err_count = 0, n_compared = 0, cyc = 0;
   ////////////////////////////////////////////////////////////////////////
   always #2.5 aclk = ~aclk;
   gpio_port dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_in(pin),
      .port_out(port_out), .port_oe(port_oe), .irq(irq));
   pin_model #(.W(32)) far (.aclk(aclk), .port_out(port_out), .port_oe(port_oe), .ext_val(ext_val),
      .ext_oe(ext_oe), .pin(pin));
   ////////////////////////////////////////////////////////////////////////
   // closing report, the one place the run ends
   task automatic print_verdict();
      $display("errors %0d compares %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // hang guard: the tests need well under a thousand cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         $display("ERROR %0t timeout", $time);
         print_verdict();
      end
   end
   // bus write: address and data offered together, each released when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bit got;
      got = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) got = 1;
      end
      bready <= 1'b0;
      `CHK(bresp, `RESP_OKAY)
      // one idle edge, so a following call never drives bready twice in one step
      @(posedge aclk);
   endtask
   // bus read: hold address until taken, rready until the answer
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      bit got;
      got = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            got = 1;
            d = rdata;
         end
      end
      rready <= 1'b0;
      `CHK(rresp, `RESP_OKAY)
      // one idle edge, so a following call never drives rready twice in one step
      @(posedge aclk);
   endtask
   // read and compare in one call
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      rd(a, rd_val);
      `CHK(rd_val, e)
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // reset state: all inputs, no interrupts
      rd_chk(`OFS_DIR, 32'h0);
      rd_chk(`OFS_IMASK, 32'h0);
      `CHK(port_oe, 32'h0)
      `CHK(irq, 1'b0)
      // low half driven by the port, high half from outside
      wr(`OFS_DATA, 32'ha5a5_0f0f);
      wr(`OFS_DIR, 32'h0000_ffff);
      ext_val <= 32'h1234_0000;
      ext_oe <= 32'hffff_0000;
      repeat (4) @(posedge aclk);
      `CHK(port_oe, 32'h0000_ffff)
      `CHK(port_out, 32'ha5a5_0f0f)
      rd_chk(`OFS_DATA, 32'h1234_0f0f);
      rd_chk(`OFS_DIR, 32'h0000_ffff);
      // edge capture: only rising bits of the new value flag
      wr(`OFS_EDGE, 32'h0);
      rd_chk(`OFS_EDGE, 32'h0);
      old_v = ext_val;
      ext_val <= 32'h8c30_0000;
      repeat (4) @(posedge aclk);
      rd_chk(`OFS_EDGE, 32'h8c30_0000 & ~old_v & 32'hffff_0000);
      repeat (4) @(posedge aclk);
      rd_chk(`OFS_EDGE, 32'h8c30_0000 & ~old_v & 32'hffff_0000);
      wr(`OFS_EDGE, 32'h1234_5678);
      rd_chk(`OFS_EDGE, 32'h0);
      // level interrupt on an outside input
      wr(`OFS_IMASK, 32'h0010_0000);
      repeat (4) @(posedge aclk);
      `CHK(irq, 1'b1)
      rd_chk(`OFS_IMASK, 32'h0010_0000);
      `CHK(irq, 1'b1)
      wr(`OFS_IMASK, 32'h0);
      repeat (4) @(posedge aclk);
      `CHK(irq, 1'b0)
      // level interrupt on a bit the port drives itself
      wr(`OFS_IMASK, 32'h0000_0001);
      repeat (4) @(posedge aclk);
      `CHK(irq, 1'b1)
      wr(`OFS_DATA, 32'ha5a5_0f0e);
      repeat (4) @(posedge aclk);
      `CHK(irq, 1'b0)
      // unaligned address: answered, nothing changes
      wr(4'h2, 32'hffff_ffff);
      rd_chk(`OFS_DIR, 32'h0000_ffff);
      rd_chk(`OFS_IMASK, 32'h0000_0001);
      print_verdict();
   end
endmodule
`default_nettype wire
